// >>> design/sao_alert_regs.sv
// Alert source enables, offset trims and alert limits of a humidity and
// temperature sensor, with the status flags and alert pin they steer.
// Assumes a byte register port fed by the serial bus front end, and raw
// conversion results that arrive with one-cycle valid pulses.
`include "sao_consts.svh"

module sao_alert_regs
  import sao_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [15:0] temp_raw,
  input wire logic temp_raw_valid,
  input wire logic [15:0] humid_raw,
  input wire logic humid_raw_valid,
  input wire logic [7:0] hum_ceiling_limit,
  input wire logic pin_enable,
  input wire logic pin_active_high,
  input wire logic pin_comparator,
  output logic [15:0] temp_result,
  output logic [15:0] humid_result,
  output logic conv_done_flag,
  output logic temp_above_flag,
  output logic temp_below_flag,
  output logic hum_above_flag,
  output logic hum_below_flag,
  output logic alert_pin,
  output logic alert_pin_oe_n
);

  // Register storage.
  sao_byte_t enables;
  sao_byte_t temp_trim;
  sao_byte_t humid_trim;
  sao_byte_t temp_floor_limit;
  sao_byte_t temp_ceiling_limit;
  sao_byte_t humid_floor_limit;
  sao_src_t flags;
  logic temp_new;
  logic humid_new;

  // Enable bits, named per source.
  wire logic conv_done_irq_en = enables[`SAO_BIT_CONV_DONE];
  wire logic temp_above_irq_en = enables[`SAO_BIT_TEMP_ABOVE];
  wire logic temp_below_irq_en = enables[`SAO_BIT_TEMP_BELOW];
  wire logic hum_above_irq_en = enables[`SAO_BIT_HUM_ABOVE];
  wire logic hum_below_irq_en = enables[`SAO_BIT_HUM_BELOW];

  // Write and read strobes per register.
  wire logic wr_enables = reg_wr && (reg_addr == `SAO_OFS_ENABLES);
  wire logic wr_temp_trim = reg_wr && (reg_addr == `SAO_OFS_TEMP_TRIM);
  wire logic wr_humid_trim = reg_wr && (reg_addr == `SAO_OFS_HUMID_TRIM);
  wire logic wr_temp_floor = reg_wr && (reg_addr == `SAO_OFS_TEMP_FLOOR);
  wire logic wr_temp_ceil = reg_wr && (reg_addr == `SAO_OFS_TEMP_CEIL);
  wire logic wr_humid_floor = reg_wr && (reg_addr == `SAO_OFS_HUMID_FLOOR);
  wire logic rd_status = reg_rd && (reg_addr == `SAO_OFS_STATUS);
  wire logic rd_result = reg_rd && (reg_addr <= `SAO_OFS_HUMID_HI);

  // Trimmed sums: trims are sign extended and shifted to code weight.
  wire logic [17:0] temp_sum = {2'b00, temp_raw} +
    {{4{temp_trim[7]}}, temp_trim, 6'h00};
  wire logic [17:0] humid_sum = {2'b00, humid_raw} +
    {{3{humid_trim[7]}}, humid_trim, 7'h00};

  // Saturate at both ends so a trim never wraps a reading around.
  wire sao_word_t temp_adj = temp_sum[17] ? 16'h0000 :
    (temp_sum[16] ? 16'hffff : temp_sum[15:0]);
  wire sao_word_t humid_adj = humid_sum[17] ? 16'h0000 :
    (humid_sum[16] ? 16'hffff : humid_sum[15:0]);

  // Live threshold conditions on the upper byte of trimmed results.
  wire logic temp_over = temp_result[15:8] > temp_ceiling_limit;
  wire logic temp_under = temp_result[15:8] < temp_floor_limit;
  wire logic hum_over = humid_result[15:8] > hum_ceiling_limit;
  wire logic hum_under = humid_result[15:8] < humid_floor_limit;

  // Set terms per flag, already gated by the source enables.
  wire sao_src_t set_terms = {
    conv_done_irq_en && (temp_new || humid_new),
    temp_above_irq_en && temp_new && temp_over,
    temp_below_irq_en && temp_new && temp_under,
    hum_above_irq_en && humid_new && hum_over,
    hum_below_irq_en && humid_new && hum_under
  };

  // Clear terms: the done flag also clears on any result byte read.
  wire sao_src_t clr_terms = {rd_status || rd_result, {4{rd_status}}};

  // Next flag value; a set in the clear cycle wins.
  wire sao_src_t next_flags = (flags & ~clr_terms) | set_terms;

  // Comparator-mode sources: live enabled compares plus the latched done flag.
  wire sao_src_t live_terms = {
    flags[4],
    temp_above_irq_en && temp_over,
    temp_below_irq_en && temp_under,
    hum_above_irq_en && hum_over,
    hum_below_irq_en && hum_under
  };

  // Pin assertion: latched flags in level mode, live compare otherwise.
  wire logic alert_active = pin_comparator ? (|live_terms) : (|flags);

  // Read data mux; unmapped offsets read zero.
  logic [7:0] next_rdata;
  always_comb begin
    unique case (reg_addr)
      `SAO_OFS_TEMP_LO: next_rdata = temp_result[7:0];
      `SAO_OFS_TEMP_HI: next_rdata = temp_result[15:8];
      `SAO_OFS_HUMID_LO: next_rdata = humid_result[7:0];
      `SAO_OFS_HUMID_HI: next_rdata = humid_result[15:8];
      `SAO_OFS_STATUS: next_rdata = {flags, 3'b000};
      `SAO_OFS_ENABLES: next_rdata = enables;
      `SAO_OFS_TEMP_TRIM: next_rdata = temp_trim;
      `SAO_OFS_HUMID_TRIM: next_rdata = humid_trim;
      `SAO_OFS_TEMP_FLOOR: next_rdata = temp_floor_limit;
      `SAO_OFS_TEMP_CEIL: next_rdata = temp_ceiling_limit;
      `SAO_OFS_HUMID_FLOOR: next_rdata = humid_floor_limit;
      default: next_rdata = 8'h00;
    endcase
  end

  // Enable register keeps only the five source bits.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      enables <= `SAO_RST_ENABLES;
    end else if (wr_enables) begin
      enables <= reg_wdata & `SAO_EN_MASK;
    end
  end

  // Trim registers.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      temp_trim <= `SAO_RST_TRIM;
      humid_trim <= `SAO_RST_TRIM;
    end else begin
      if (wr_temp_trim) begin
        temp_trim <= reg_wdata;
      end
      if (wr_humid_trim) begin
        humid_trim <= reg_wdata;
      end
    end
  end

  // Limit registers.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      temp_floor_limit <= `SAO_RST_FLOOR;
      temp_ceiling_limit <= `SAO_RST_CEIL;
      humid_floor_limit <= `SAO_RST_FLOOR;
    end else begin
      if (wr_temp_floor) begin
        temp_floor_limit <= reg_wdata;
      end
      if (wr_temp_ceil) begin
        temp_ceiling_limit <= reg_wdata;
      end
      if (wr_humid_floor) begin
        humid_floor_limit <= reg_wdata;
      end
    end
  end

  // Trimmed results are captured with their valid pulse, then compared.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      temp_result <= 16'h0000;
      humid_result <= 16'h0000;
      temp_new <= 1'b0;
      humid_new <= 1'b0;
    end else begin
      temp_new <= temp_raw_valid;
      humid_new <= humid_raw_valid;
      if (temp_raw_valid) begin
        temp_result <= temp_adj;
      end
      if (humid_raw_valid) begin
        humid_result <= humid_adj;
      end
    end
  end

  // Status flags.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      flags <= 5'h00;
    end else begin
      flags <= next_flags;
    end
  end

  // Registered read data and pin drive.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
      alert_pin <= 1'b0;
      alert_pin_oe_n <= 1'b1;
    end else begin
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
      alert_pin <= pin_active_high ? alert_active : !alert_active;
      alert_pin_oe_n <= !pin_enable;
    end
  end

  // Flag outputs, one per source.
  assign conv_done_flag = flags[4];
  assign temp_above_flag = flags[3];
  assign temp_below_flag = flags[2];
  assign hum_above_flag = flags[1];
  assign hum_below_flag = flags[0];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // Done flag appears only when its source is enabled.
  AST_DONE_GATED: assert property (
    $rose(conv_done_flag) |-> $past(conv_done_irq_en))
    else $error("Done flag rose while its source was disabled.");

  // A new hot temperature with the source enabled sets the above flag.
  AST_TEMP_ABOVE_SET: assert property (
    temp_new && temp_above_irq_en && temp_over |=> temp_above_flag)
    else $error("Temperature above flag missed a crossing.");

  // A new cold temperature with the source enabled sets the below flag.
  AST_TEMP_BELOW_SET: assert property (
    temp_new && temp_below_irq_en && temp_under |=> temp_below_flag)
    else $error("Temperature below flag missed a crossing.");

  // Humidity above flag never rises with its source disabled.
  AST_HUM_ABOVE_GATED: assert property (
    $rose(hum_above_flag) |-> $past(hum_above_irq_en) && $past(humid_new))
    else $error("Humidity above flag rose without an enabled event.");

  // Humidity below flag follows a new low reading when enabled.
  AST_HUM_BELOW_SET: assert property (
    humid_new && hum_below_irq_en && hum_under |=> hum_below_flag)
    else $error("Humidity below flag missed a crossing.");

  // A write keeps the five source bits and leaves the reserved bits zero.
  AST_RESERVED_ZERO: assert property (
    wr_enables |=> enables == ($past(reg_wdata) & `SAO_EN_MASK))
    else $error("Enable register does not hold the masked write.");

  // A status read with no new event leaves the threshold flags clear.
  AST_STATUS_CLEAR: assert property (
    rd_status && !temp_new && !humid_new |=> flags[3:0] == 4'h0)
    else $error("Threshold flags survived a status read.");

  // A result read clears the done flag unless a conversion lands.
  AST_DONE_CLEAR: assert property (
    rd_result && !temp_new && !humid_new |=> !conv_done_flag)
    else $error("Done flag survived a result read.");

  // An unclamped captured temperature equals the raw value plus the shifted trim.
  AST_TEMP_TRIM: assert property (
    temp_raw_valid && !temp_sum[17] && !temp_sum[16]
      |=> temp_result == $past(temp_sum[15:0]))
    else $error("Trimmed temperature does not match the sum.");

  // Pin level matches polarity and the latched flags in level mode when enabled.
  AST_PIN_FOLLOWS: assert property (
    ##1 $past(resetn) && $past(pin_enable) && !$past(pin_comparator)
      |-> alert_pin_oe_n == 1'b0 &&
          alert_pin == ($past(pin_active_high) ~^ $past(|flags)))
    else $error("Alert pin does not follow the latched flags.");

  // Registers hold their reset values on the first edge after reset.
  AST_RESET_VALUES: assert property (
    !$past(resetn) |-> enables == `SAO_RST_ENABLES && temp_trim == `SAO_RST_TRIM &&
      humid_trim == `SAO_RST_TRIM && temp_floor_limit == `SAO_RST_FLOOR &&
      temp_ceiling_limit == `SAO_RST_CEIL && humid_floor_limit == `SAO_RST_FLOOR &&
      flags == 5'h00)
    else $error("A register left reset with a wrong value.");

  // The done flag sets after a conversion while its source is enabled.
  AST_DONE_SET: assert property (
    conv_done_irq_en && (temp_new || humid_new) |=> conv_done_flag)
    else $error("Done flag missed a conversion.");

  // Temperature above flag never rises with its source disabled.
  AST_TEMP_ABOVE_GATED: assert property (
    $rose(temp_above_flag) |-> $past(temp_above_irq_en) && $past(temp_new))
    else $error("Temperature above flag rose without an enabled event.");

  // Temperature below flag never rises with its source disabled.
  AST_TEMP_BELOW_GATED: assert property (
    $rose(temp_below_flag) |-> $past(temp_below_irq_en) && $past(temp_new))
    else $error("Temperature below flag rose without an enabled event.");

  // A new humid reading over the ceiling sets the above flag when enabled.
  AST_HUM_ABOVE_SET: assert property (
    humid_new && hum_above_irq_en && hum_over |=> hum_above_flag)
    else $error("Humidity above flag missed a crossing.");

  // Humidity below flag never rises with its source disabled.
  AST_HUM_BELOW_GATED: assert property (
    $rose(hum_below_flag) |-> $past(hum_below_irq_en) && $past(humid_new))
    else $error("Humidity below flag rose without an enabled event.");

  // An unclamped humidity equals the raw code plus the trim at bit 7 weight.
  AST_HUM_TRIM: assert property (
    humid_raw_valid && !humid_sum[17] && !humid_sum[16]
      |=> humid_result == $past(humid_raw) + {$past(humid_trim[7]), $past(humid_trim), 7'h00})
    else $error("Trimmed humidity does not match the raw code plus trim.");

  // A negative trim that pulls a reading below zero clamps it to zero.
  AST_TEMP_CLAMP: assert property (
    temp_raw_valid && temp_sum[17] |=> temp_result == 16'h0000)
    else $error("Temperature under range did not clamp to zero.");

  // A status read returns the flags as they stood before the clear.
  AST_STATUS_DATA: assert property (
    rd_status |=> reg_rdata == {$past(flags), 3'b000})
    else $error("Status read data does not match the flags.");

  // Comparator mode drives the pin from the live enabled compares.
  AST_PIN_LIVE: assert property (
    ##1 $past(resetn) && $past(pin_enable) && $past(pin_comparator)
      |-> alert_pin == ($past(pin_active_high) ~^ $past(|live_terms)))
    else $error("Alert pin does not follow the live compares.");

  // A disabled pin is released.
  AST_PIN_RELEASED: assert property (
    ##1 $past(resetn) && !$past(pin_enable) |-> alert_pin_oe_n)
    else $error("Alert pin is driven while disabled.");

endmodule

// >>> design/sao_consts.svh
// Offsets, field positions, reset values and scaling shifts of the alert,
// trim and limit register group.
// Assumes it is included once per compilation unit by its bare name.
`ifndef SAO_CONSTS_SVH
`define SAO_CONSTS_SVH

// Register offsets on the byte-wide register port.
`define SAO_OFS_TEMP_LO 8'h00
`define SAO_OFS_TEMP_HI 8'h01
`define SAO_OFS_HUMID_LO 8'h02
`define SAO_OFS_HUMID_HI 8'h03
`define SAO_OFS_STATUS 8'h04
`define SAO_OFS_ENABLES 8'h07
`define SAO_OFS_TEMP_TRIM 8'h08
`define SAO_OFS_HUMID_TRIM 8'h09
`define SAO_OFS_TEMP_FLOOR 8'h0a
`define SAO_OFS_TEMP_CEIL 8'h0b
`define SAO_OFS_HUMID_FLOOR 8'h0c

// Bit positions shared by the enable and status registers.
`define SAO_BIT_CONV_DONE 7
`define SAO_BIT_TEMP_ABOVE 6
`define SAO_BIT_TEMP_BELOW 5
`define SAO_BIT_HUM_ABOVE 4
`define SAO_BIT_HUM_BELOW 3
`define SAO_EN_MASK 8'hf8

// Reset values.
`define SAO_RST_ENABLES 8'h00
`define SAO_RST_TRIM 8'h00
`define SAO_RST_FLOOR 8'h00
`define SAO_RST_CEIL 8'hff

// Left shift that places trim bit 0 on the result code weight.
`define SAO_TEMP_TRIM_SHIFT 6
`define SAO_HUMID_TRIM_SHIFT 7

`endif

// >>> design/sao_pkg.sv
// Types shared by the alert, trim and limit register group.
// Assumes nothing beyond a SystemVerilog compiler.
package sao_pkg;
  typedef logic [7:0] sao_byte_t;
  typedef logic [15:0] sao_word_t;
  typedef logic [4:0] sao_src_t;
endpackage

// >>> verif/sao_host_model.sv
// Host controller model that drives the byte register port of the alert block.
// Assumes one shared rising-edge clock and one-cycle read and write strobes.
module sao_host_model (
  input wire logic clk_sys,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd
);
  timeunit 1ns;
  timeprecision 1ps;

  // Strobes idle low from time zero.
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end

  // One byte write; released data shows the inverse so stale bytes never match.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask

  // One byte read; the data is taken by the bench monitor a cycle later.
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
  endtask
endmodule

// >>> verif/tb_sao_alert_regs.sv
// Self-checking bench for the alert, trim and limit register group.
// Assumes the host model above; the pin starts in level mode, active high.
module tb_sao_alert_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import sao_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, rd_d = 1'b0;
  logic [15:0] temp_raw = 16'h0000, humid_raw = 16'h0000, temp_result, humid_result;
  logic temp_raw_valid = 1'b0, humid_raw_valid = 1'b0;
  logic [7:0] hum_ceiling_limit = 8'h80;
  logic pin_enable = 1'b1, pin_active_high = 1'b1, pin_comparator = 1'b0;
  logic conv_done_flag, temp_above_flag, temp_below_flag, hum_above_flag, hum_below_flag;
  logic alert_pin, alert_pin_oe_n;
  wire logic [4:0] flag_vec = {conv_done_flag, temp_above_flag, temp_below_flag,
    hum_above_flag, hum_below_flag};
  logic [7:0] q[$];
  int fails = 0, comparisons = 0;

  sao_host_model host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd));

  sao_alert_regs uut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .temp_raw(temp_raw), .temp_raw_valid(temp_raw_valid), .humid_raw(humid_raw),
    .humid_raw_valid(humid_raw_valid), .hum_ceiling_limit(hum_ceiling_limit),
    .pin_enable(pin_enable), .pin_active_high(pin_active_high),
    .pin_comparator(pin_comparator), .temp_result(temp_result),
    .humid_result(humid_result), .conv_done_flag(conv_done_flag),
    .temp_above_flag(temp_above_flag), .temp_below_flag(temp_below_flag),
    .hum_above_flag(hum_above_flag), .hum_below_flag(hum_below_flag),
    .alert_pin(alert_pin), .alert_pin_oe_n(alert_pin_oe_n));

  // Free-running 100 MHz clock.
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // Prints counts and the verdict, then ends the run.
  task automatic conclude();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] s);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  // Notes the expected byte, then reads it through the host.
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    q.push_back(e);
    host.rd(a);
  endtask

  // One conversion pulse on both inputs; released codes show their inverse.
  task automatic conv(input logic [15:0] t, input logic [15:0] h);
    @(posedge clk_sys);
    temp_raw <= t;
    humid_raw <= h;
    temp_raw_valid <= 1'b1;
    humid_raw_valid <= 1'b1;
    @(posedge clk_sys);
    temp_raw_valid <= 1'b0;
    humid_raw_valid <= 1'b0;
    temp_raw <= ~t;
    humid_raw <= ~h;
    repeat (3) @(posedge clk_sys);
  endtask

  // Takes the oldest note whenever read data appears and compares it.
  always @(posedge clk_sys) begin
    if (rd_d) begin
      if (q.size() == 0) begin
        fails++;
        $display("mismatch reg_rdata expected none seen %h", reg_rdata);
      end else begin
        cmp("reg_rdata", {8'h00, q.pop_front()}, {8'h00, reg_rdata});
      end
    end
    rd_d <= reg_rd;
  end

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    $display("mismatch watchdog expected done seen hang");
    conclude();
  end

  // Main sequence.
  initial begin
    logic [31:0] seed;
    logic [7:0] rv [0:5];
    logic [15:0] tt [3:7];
    logic [15:0] hh [3:7];
    int k;
    seed = 32'h744b7b35;
    rv = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00};
    tt = '{16'h6000, 16'h6000, 16'h1000, 16'hc000, 16'h6000};
    hh = '{16'h1000, 16'hc000, 16'h6000, 16'h6000, 16'h6000};
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int i = 0; i < 6; i++) chk(8'h07 + i, rv[i]);
    chk(8'h20, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      host.wr(8'h07 + i, seed[7:0]);
      chk(8'h07 + i, (i == 0) ? (seed[7:0] & 8'hf8) : seed[7:0]);
    end
    $display("test readback done");
    host.wr(8'h07, 8'h00);
    host.wr(8'h08, 8'h01);
    host.wr(8'h09, 8'hff);
    host.wr(8'h0a, 8'h40);
    host.wr(8'h0b, 8'h80);
    host.wr(8'h0c, 8'h40);
    conv(16'h6000, 16'h6000);
    chk(8'h00, 8'h40);
    chk(8'h01, 8'h60);
    chk(8'h02, 8'h80);
    chk(8'h03, 8'h5f);
    cmp("temp_result", 16'h6040, temp_result);
    cmp("humid_result", 16'h5f80, humid_result);
    chk(8'h04, 8'h00);
    cmp("alert_pin", 16'h0000, {15'h0000, alert_pin});
    host.wr(8'h08, 8'h80);
    conv(16'h0100, 16'h6000);
    chk(8'h01, 8'h00);
    cmp("temp_result", 16'h0000, temp_result);
    host.wr(8'h08, 8'h00);
    host.wr(8'h09, 8'h00);
    $display("test trims done");
    for (int i = 3; i < 8; i++) begin
      host.wr(8'h07, 8'h01 << i);
      conv(tt[i], hh[i]);
      cmp("alert_pin", 16'h0001, {15'h0000, alert_pin});
      cmp("alert_pin_oe_n", 16'h0000, {15'h0000, alert_pin_oe_n});
      cmp("flags", 16'h0001 << (i - 3), {11'h000, flag_vec});
      chk(8'h04, 8'h01 << i);
      chk(8'h04, 8'h00);
      repeat (2) @(posedge clk_sys);
      cmp("alert_pin", 16'h0000, {15'h0000, alert_pin});
    end
    conv(16'h6000, 16'h6000);
    chk(8'h01, 8'h60);
    chk(8'h04, 8'h00);
    $display("test alert sources done");
    host.wr(8'h07, 8'h40);
    pin_comparator <= 1'b1;
    pin_active_high <= 1'b0;
    conv(16'hc000, 16'h6000);
    cmp("alert_pin", 16'h0000, {15'h0000, alert_pin});
    chk(8'h04, 8'h40);
    chk(8'h04, 8'h00);
    repeat (2) @(posedge clk_sys);
    cmp("alert_pin", 16'h0000, {15'h0000, alert_pin});
    conv(16'h6000, 16'h6000);
    cmp("alert_pin", 16'h0001, {15'h0000, alert_pin});
    pin_enable <= 1'b0;
    repeat (2) @(posedge clk_sys);
    cmp("alert_pin_oe_n", 16'h0001, {15'h0000, alert_pin_oe_n});
    $display("test comparator mode done");
    for (k = 0; k < 20 && q.size() > 0; k++) @(posedge clk_sys);
    if (q.size() > 0) begin
      fails++;
      $display("mismatch read queue expected 0 seen %0d", q.size());
    end
    conclude();
  end
endmodule
